// ===== rtl/sdp_cmd_unit.sv
// How it works
// - twelve-bit command word, sent MSB first
// - sample data on rising clock, latch at CS rise
// - data code is linear, D0 weight one
// - codes 0 down, 1-8 channels, 9 up
// - select bit 0 I/O, 1 converter
// - direction bit 0 input, 1 output
// - pins captured at next CS fall
// - captured byte out from fourth falling edge
// - s2p data on pins after CS rise
// - channel code updated after CS rise
// - serial out echoes shift register otherwise
// - reset gives power-down, all pins high impedance
// - only reset clears the shift register
// - power-down turns converter channels into I/O
`timescale 1ns/1ps
`include "sdp_defs.svh"

module sdp_cmd_unit #(
  parameter int CHANNELS = 8,
  parameter int CODE_W = 8,
  parameter int CHAN_AW = 3
) (
  // system clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // serial link
  input wire logic serial_clk_i,
  input wire logic chip_select_n_i,
  input wire logic serial_data_in_i,
  input wire logic external_reset_n_i,
  output logic serial_out_o,
  // channel pins, oe low while driving
  input wire logic [CHANNELS-1:0] channel_pins_i,
  output logic [CHANNELS-1:0] channel_pins_o,
  output logic [CHANNELS-1:0] channel_pins_oe_n_o,
  // converter control
  output logic power_down_o,
  output logic [CHANNELS-1:0] dac_mode_o,
  output logic dac_load_o,
  output logic [CHAN_AW-1:0] dac_load_chan_o,
  output logic [CODE_W-1:0] dac_load_code_o,
  input wire logic [CHAN_AW-1:0] dac_rd_sel_i,
  output logic [CODE_W-1:0] dac_rd_code_o,
  // status
  output logic [CHANNELS-1:0] io_dir_o,
  output logic p2s_pending_o
);

  function automatic sdp_pkg::sdp_op_t decode_op(input logic [3:0] cmd);
    sdp_pkg::sdp_op_t op;
    op = sdp_pkg::OP_NONE;
    case (cmd)
      `SDP_CMD_PWR_DOWN: op = sdp_pkg::OP_PWR_DOWN;
      `SDP_CMD_PWR_UP: op = sdp_pkg::OP_PWR_UP;
      `SDP_CMD_DAC_SEL: op = sdp_pkg::OP_DAC_SEL;
      `SDP_CMD_SER2PAR: op = sdp_pkg::OP_SER2PAR;
      `SDP_CMD_PAR2SER: op = sdp_pkg::OP_PAR2SER;
      `SDP_CMD_IO_DIR: op = sdp_pkg::OP_IO_DIR;
      `SDP_CMD_IGN_A, `SDP_CMD_IGN_B: op = sdp_pkg::OP_NONE;
      default: begin
        if (cmd >= `SDP_CMD_CHAN_FIRST && cmd <= `SDP_CMD_CHAN_LAST) begin
          op = sdp_pkg::OP_CHAN;
        end
      end
    endcase
    return op;
  endfunction

  // ---------------- reset ----------------
  logic ext_rst_meta_r;
  logic ext_rst_sync_r;
  logic dev_rst;
  logic link_clr_r;

  always_ff @(posedge clk_sys_i) begin
    ext_rst_meta_r <= external_reset_n_i;
    ext_rst_sync_r <= ext_rst_meta_r;
  end

  assign dev_rst = srst_i | ~ext_rst_sync_r;

  // registered so the link side sees a glitch-free clear
  always_ff @(posedge clk_sys_i) begin
    link_clr_r <= dev_rst;
  end

  // ---------------- link domain ----------------
  logic [`SDP_WORD_W-1:0] shreg_r;
  logic [3:0] rise_cnt_r;
  logic send_meta_r;
  logic send_sync_r;
  logic so_r;
  logic [CODE_W-1:0] par_cap_r;
  logic [3:0] so_idx;

  // chip select high does not clear this, only reset does
  always_ff @(posedge serial_clk_i or posedge link_clr_r) begin
    if (link_clr_r) begin
      shreg_r <= `SDP_RST_WORD;
    end else if (!chip_select_n_i) begin
      shreg_r <= {shreg_r[`SDP_WORD_W-2:0], serial_data_in_i};
    end
  end

  // counts rising edges per select-low period; reset clear avoids an unknown first frame
  always_ff @(posedge serial_clk_i or posedge chip_select_n_i or posedge link_clr_r) begin
    if (chip_select_n_i || link_clr_r) begin
      rise_cnt_r <= 4'h0;
    end else if (rise_cnt_r != `SDP_RISE_MAX) begin
      rise_cnt_r <= rise_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge serial_clk_i or posedge link_clr_r) begin
    if (link_clr_r) begin
      send_meta_r <= 1'b0;
      send_sync_r <= 1'b0;
    end else begin
      send_meta_r <= p2s_pending_o;
      send_sync_r <= send_meta_r;
    end
  end

  assign so_idx = `SDP_P2S_LAST - rise_cnt_r;

  // falling edges before the first rising edge leave rise_cnt_r at zero
  always_ff @(negedge serial_clk_i or posedge link_clr_r) begin
    if (link_clr_r) begin
      so_r <= 1'b0;
    end else if (send_sync_r && rise_cnt_r >= `SDP_P2S_FIRST && rise_cnt_r <= `SDP_P2S_LAST) begin
      so_r <= par_cap_r[so_idx[2:0]];
    end else begin
      so_r <= shreg_r[`SDP_WORD_W-1];
    end
  end

  assign serial_out_o = so_r;

  // ---------------- system domain: link sampling ----------------
  logic cs_meta_r;
  logic cs_sync_r;
  logic cs_prev_r;
  logic cs_rise;
  logic cs_fall;
  logic [CHANNELS-1:0] pin_meta_r;
  logic [CHANNELS-1:0] pin_sync_r;

  always_ff @(posedge clk_sys_i) begin
    if (dev_rst) begin
      cs_meta_r <= 1'b1;
      cs_sync_r <= 1'b1;
      cs_prev_r <= 1'b1;
    end else begin
      cs_meta_r <= chip_select_n_i;
      cs_sync_r <= cs_meta_r;
      cs_prev_r <= cs_sync_r;
    end
  end

  assign cs_rise = cs_sync_r & ~cs_prev_r;
  assign cs_fall = ~cs_sync_r & cs_prev_r;

  always_ff @(posedge clk_sys_i) begin
    pin_meta_r <= channel_pins_i;
    pin_sync_r <= pin_meta_r;
  end

  // shreg_r is frozen while chip select is high, so reading it after the
  // synchronised rise is safe; the host must hold select high long enough
  logic [3:0] cmd_f;
  logic [CODE_W-1:0] data_f;
  sdp_pkg::sdp_op_t op;

  assign cmd_f = shreg_r[`SDP_CMD_MSB:`SDP_CMD_LSB];
  assign data_f = shreg_r[`SDP_DATA_MSB:`SDP_DATA_LSB];
  assign op = cs_rise ? decode_op(cmd_f) : sdp_pkg::OP_NONE;

  // ---------------- power and mode state ----------------
  logic pwr_down_r;
  logic [CHANNELS-1:0] dac_sel_r;
  logic [CHANNELS-1:0] io_dir_r;
  logic [CHANNELS-1:0] par_out_r;

  always_ff @(posedge clk_sys_i) begin
    if (dev_rst) begin
      pwr_down_r <= 1'b1;
    end else if (op == sdp_pkg::OP_PWR_DOWN) begin
      pwr_down_r <= 1'b1;
    end else if (op == sdp_pkg::OP_PWR_UP) begin
      pwr_down_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (dev_rst) begin
      dac_sel_r <= `SDP_RST_DAC_SEL;
    end else if (op == sdp_pkg::OP_PWR_DOWN) begin
      dac_sel_r <= '0;
    end else if (op == sdp_pkg::OP_DAC_SEL) begin
      dac_sel_r <= data_f;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (dev_rst) begin
      io_dir_r <= `SDP_RST_IO_DIR;
    end else if (op == sdp_pkg::OP_IO_DIR) begin
      io_dir_r <= data_f;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (dev_rst) begin
      par_out_r <= `SDP_RST_PAR_OUT;
    end else if (op == sdp_pkg::OP_SER2PAR) begin
      par_out_r <= data_f;
    end
  end

  // ---------------- pin drivers ----------------
  // a pin is driven digitally only when it is in I/O mode and set as output;
  // converter pins are driven by the analog side through dac_mode_o
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_pin
      always_ff @(posedge clk_sys_i) begin
        if (dev_rst) begin
          channel_pins_oe_n_o[g] <= 1'b1;
          channel_pins_o[g] <= 1'b0;
        end else begin
          channel_pins_oe_n_o[g] <= ~(io_dir_r[g] & ~dac_sel_r[g]);
          channel_pins_o[g] <= par_out_r[g];
        end
      end
    end
  endgenerate

  assign dac_mode_o = dac_sel_r;
  assign power_down_o = pwr_down_r;
  assign io_dir_o = io_dir_r;

  // ---------------- converter codes ----------------
  logic wr_en;
  logic [CHAN_AW-1:0] wr_chan;

  assign wr_en = (op == sdp_pkg::OP_CHAN);
  assign wr_chan = CHAN_AW'(cmd_f - `SDP_CMD_CHAN_FIRST);

  sdp_code_mem #(
    .DEPTH(CHANNELS),
    .WIDTH(CODE_W),
    .AW(CHAN_AW)
  ) u_code_mem (
    .clk_sys_i(clk_sys_i),
    .srst_i(dev_rst),
    .wr_en_i(wr_en),
    .wr_addr_i(wr_chan),
    .wr_data_i(data_f),
    .rd_addr_i(dac_rd_sel_i),
    .rd_data_o(dac_rd_code_o)
  );

  // one-cycle load strobe toward the converter of that channel
  always_ff @(posedge clk_sys_i) begin
    if (dev_rst) begin
      dac_load_o <= 1'b0;
      dac_load_chan_o <= '0;
      dac_load_code_o <= CODE_W'(`SDP_RST_CODE);
    end else begin
      dac_load_o <= wr_en;
      if (wr_en) begin
        dac_load_chan_o <= wr_chan;
        dac_load_code_o <= data_f;
      end
    end
  end

  // ---------------- parallel-to-serial ----------------
  sdp_pkg::sdp_p2s_t p2s_st_r;

  always_ff @(posedge clk_sys_i) begin
    if (dev_rst) begin
      p2s_st_r <= sdp_pkg::P2S_IDLE;
    end else begin
      case (p2s_st_r)
        sdp_pkg::P2S_IDLE: begin
          if (op == sdp_pkg::OP_PAR2SER) begin
            p2s_st_r <= sdp_pkg::P2S_ARMED;
          end
        end
        sdp_pkg::P2S_ARMED: begin
          if (cs_fall) begin
            p2s_st_r <= sdp_pkg::P2S_SEND;
          end
        end
        sdp_pkg::P2S_SEND: begin
          if (op == sdp_pkg::OP_PAR2SER) begin
            p2s_st_r <= sdp_pkg::P2S_ARMED;
          end else if (cs_rise) begin
            p2s_st_r <= sdp_pkg::P2S_IDLE;
          end
        end
        default: p2s_st_r <= sdp_pkg::P2S_IDLE;
      endcase
    end
  end

  // held steady through the sending frame, read by the link side only
  // once the synchronised send flag is up
  always_ff @(posedge clk_sys_i) begin
    if (dev_rst) begin
      par_cap_r <= '0;
    end else if (p2s_st_r == sdp_pkg::P2S_ARMED && cs_fall) begin
      par_cap_r <= pin_sync_r;
    end
  end

  assign p2s_pending_o = (p2s_st_r == sdp_pkg::P2S_SEND);

endmodule

// ===== rtl/sdp_defs.svh
`ifndef SDP_DEFS_SVH
`define SDP_DEFS_SVH

// command word layout, first bit on the wire is bit 11
`define SDP_WORD_W 12
`define SDP_CMD_MSB 11
`define SDP_CMD_LSB 8
`define SDP_DATA_MSB 7
`define SDP_DATA_LSB 0

// command field codes
`define SDP_CMD_PWR_DOWN 4'h0
`define SDP_CMD_CHAN_FIRST 4'h1
`define SDP_CMD_CHAN_LAST 4'h8
`define SDP_CMD_PWR_UP 4'h9
`define SDP_CMD_IGN_A 4'hA
`define SDP_CMD_IGN_B 4'hB
`define SDP_CMD_DAC_SEL 4'hC
`define SDP_CMD_SER2PAR 4'hD
`define SDP_CMD_PAR2SER 4'hE
`define SDP_CMD_IO_DIR 4'hF

// reset values
`define SDP_RST_CODE 8'h00
`define SDP_RST_DAC_SEL 8'h00
`define SDP_RST_IO_DIR 8'h00
`define SDP_RST_PAR_OUT 8'h00
`define SDP_RST_WORD 12'h000

// parallel-to-serial timing, in counted rising edges of the link clock
`define SDP_P2S_FIRST 4'h4
`define SDP_P2S_LAST 4'hB
`define SDP_RISE_MAX 4'hF

`endif

// ===== rtl/sdp_pkg.sv
package sdp_pkg;

  typedef enum logic [1:0] {
    P2S_IDLE,
    P2S_ARMED,
    P2S_SEND
  } sdp_p2s_t;

  typedef enum logic [2:0] {
    OP_PWR_DOWN,
    OP_PWR_UP,
    OP_CHAN,
    OP_DAC_SEL,
    OP_SER2PAR,
    OP_PAR2SER,
    OP_IO_DIR,
    OP_NONE
  } sdp_op_t;

endpackage

// ===== rtl/sdp_code_mem.sv
`timescale 1ns/1ps
`include "sdp_defs.svh"

module sdp_code_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 8,
  parameter int AW = 3
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  // read port
  input wire logic [AW-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem_r [DEPTH];

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= WIDTH'(`SDP_RST_CODE);
      end
    end else if (wr_en_i) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rd_data_o <= WIDTH'(`SDP_RST_CODE);
    end else begin
      rd_data_o <= mem_r[rd_addr_i];
    end
  end

endmodule

// ===== bench/sdp_cmd_unit_props.sv
`timescale 1ns/1ps
module sdp_cmd_unit_props #(
  parameter int CHANNELS = 8
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // link
  input wire logic chip_select_n_i,
  // outputs watched
  input wire logic [CHANNELS-1:0] channel_pins_o,
  input wire logic [CHANNELS-1:0] channel_pins_oe_n_o,
  input wire logic power_down_o,
  input wire logic [CHANNELS-1:0] dac_mode_o,
  input wire logic [CHANNELS-1:0] io_dir_o,
  input wire logic dac_load_o,
  input wire logic p2s_pending_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);
  a_load_one_pulse: assert property (dac_load_o |=> !dac_load_o)
    else $error("load pulse too long");
  a_load_after_cs: assert property (dac_load_o |-> $past(chip_select_n_i, 3))
    else $error("load not timed by select rise");
  a_reset_state: assert property (disable iff (1'b0) srst_i |=> power_down_o && dac_mode_o == '0
    && io_dir_o == '0 && &channel_pins_oe_n_o) else $error("bad reset state");
  a_pdown_clears_mode: assert property ($rose(power_down_o) |-> dac_mode_o == '0)
    else $error("converter mode kept in power-down");
  // oe lags the mode and direction registers by one edge
  a_drive_needs_dir: assert property ((~channel_pins_oe_n_o & ~($past(io_dir_o) & ~$past(dac_mode_o))) == '0)
    else $error("pin driven without output direction");
  a_state_after_cs: assert property (($changed(dac_mode_o) || $changed(io_dir_o) || $changed(power_down_o))
    |-> $past(chip_select_n_i, 3)) else $error("state changed off select rise");
  a_pins_after_cs: assert property ($changed(channel_pins_o) |-> $past(chip_select_n_i, 4))
    else $error("pins changed off select rise");
  a_p2s_start: assert property ($rose(p2s_pending_o) |-> !$past(chip_select_n_i, 3))
    else $error("capture not on select fall");
  a_p2s_end: assert property ($fell(p2s_pending_o) |-> $past(chip_select_n_i, 3))
    else $error("send frame end not on select rise");
  c_load: cover property (dac_load_o);
  c_p2s: cover property ($rose(p2s_pending_o));
  c_pdown_exit: cover property ($fell(power_down_o));
endmodule

bind sdp_cmd_unit sdp_cmd_unit_props #(.CHANNELS(CHANNELS)) u_props (.clk_sys_i, .srst_i, .chip_select_n_i,
  .channel_pins_o, .channel_pins_oe_n_o, .power_down_o, .dac_mode_o, .io_dir_o, .dac_load_o, .p2s_pending_o);

// ===== bench/sdp_host_model.sv
`timescale 1ns/1ps
module sdp_host_model (
  // link toward the device
  output logic serial_clk_o,
  output logic chip_select_n_o,
  output logic serial_data_o,
  output logic external_reset_n_o,
  input wire logic serial_out_i
);
  localparam int HALF = 80;
  initial begin
    serial_clk_o = 1'b0;
    chip_select_n_o = 1'b1;
    serial_data_o = 1'b0;
    external_reset_n_o = 1'b1;
  end
  // n below 12 cuts the frame short; odd 3 ns offset keeps edges off the system clock
  task automatic frame(input logic [11:0] w, input int n, output logic [7:0] so);
    so = 8'h00;
    #3;
    chip_select_n_o = 1'b0;
    for (int k = 1; k <= n + 1; k++) begin
      #(HALF / 2);
      if (k >= 5 && k <= 12) so[12-k] = serial_out_i;
      if (k > n) break;
      serial_data_o = w[12-k];
      #(HALF / 2);
      serial_clk_o = 1'b1;
      #(HALF);
      serial_clk_o = 1'b0;
    end
    chip_select_n_o = 1'b1;
    // released line shows the inverse so a stale bit cannot pass
    serial_data_o = ~serial_data_o;
    #400;
  endtask
  task automatic pin_reset();
    external_reset_n_o = 1'b0;
    #500;
    external_reset_n_o = 1'b1;
    #500;
  endtask
endmodule

// ===== bench/sdp_cmd_unit_tb_top.sv
`timescale 1ns/1ps
module sdp_cmd_unit_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic sclk, csn, sdi, rstn, so, load, pdn, pend;
  logic [2:0] lchan;
  logic [2:0] rsel = 3'h0;
  logic [7:0] pins_o, oe_n, mode, dir, lcode, rcode, got, ext_pins = 8'h00;
  int n_fail = 0;
  int check_count = 0;
  int n_load = 0;
  int nl0;
  wire logic [7:0] pin_lvl = (~oe_n & pins_o) | (oe_n & ext_pins);
  always #25 clk = ~clk;
  always @(posedge clk) if (load === 1'b1) n_load <= n_load + 1;
  sdp_cmd_unit dut (.clk_sys_i(clk), .srst_i(srst), .serial_clk_i(sclk), .chip_select_n_i(csn),
    .serial_data_in_i(sdi), .external_reset_n_i(rstn), .serial_out_o(so), .channel_pins_i(pin_lvl),
    .channel_pins_o(pins_o), .channel_pins_oe_n_o(oe_n), .power_down_o(pdn), .dac_mode_o(mode),
    .dac_load_o(load), .dac_load_chan_o(lchan), .dac_load_code_o(lcode), .dac_rd_sel_i(rsel),
    .dac_rd_code_o(rcode), .io_dir_o(dir), .p2s_pending_o(pend));
  sdp_host_model host (.serial_clk_o(sclk), .chip_select_n_o(csn), .serial_data_o(sdi),
    .external_reset_n_o(rstn), .serial_out_i(so));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic send(input logic [11:0] w);
    host.frame(w, 12, got);
  endtask
  task automatic rd_chk(input int c, input logic [7:0] e);
    @(negedge clk) rsel = 3'(c);
    @(negedge clk);
    chk(rcode, e);
  endtask
  task automatic t_reset();
    chk(8'(pdn), 8'h01);
    chk(mode, 8'h00);
    chk(oe_n, 8'hFF);
    for (int c = 0; c < 8; c++) rd_chk(c, 8'h00);
  endtask
  task automatic t_init();
    send(12'h900);
    chk(8'(pdn), 8'h00);
    send(12'hC0F);
    chk(mode, 8'h0F);
    send(12'hFF0);
    chk(dir, 8'hF0);
    chk(oe_n, 8'h0F);
    for (int c = 1; c <= 4; c++) send({4'(c), 8'h80});
    chk(lcode, 8'h80);
  endtask
  task automatic t_chan();
    for (int c = 1; c <= 8; c++) begin
      nl0 = n_load;
      send({4'(c), 8'hFF >> (c - 1)});
      chk(8'(n_load - nl0), 8'h01);
      chk(8'(lchan), 8'(c - 1));
      chk(lcode, 8'hFF >> (c - 1));
    end
    for (int c = 0; c < 8; c++) rd_chk(c, 8'hFF >> c);
    nl0 = n_load;
    send(12'hA33);
    send(12'hB44);
    chk(got, 8'h33);
    chk(8'(n_load - nl0), 8'h00);
    chk(mode, 8'h0F);
  endtask
  task automatic t_s2p();
    send(12'hD5A);
    chk(pins_o, 8'h5A);
  endtask
  task automatic t_p2s();
    @(negedge clk) ext_pins = 8'hC3;
    send(12'hF00);
    chk(oe_n, 8'hFF);
    send(12'hE00);
    // the sending frame itself restores the output directions at its end
    host.frame(12'hFF0, 12, got);
    chk(got, 8'hC3);
    chk(8'(pend), 8'h00);
    chk(oe_n, 8'h0F);
  endtask
  task automatic t_partial();
    send(12'hA00);
    chk(got, 8'hF0);
    // six bits after A00 leave 024 in the shift register: power-down
    host.frame(12'h900, 6, got);
    chk(8'(pdn), 8'h01);
    chk(mode, 8'h00);
    chk(oe_n, 8'h0F);
    host.pin_reset();
    chk(dir, 8'h00);
    chk(oe_n, 8'hFF);
    chk(pins_o, 8'h00);
    rd_chk(3, 8'h00);
  endtask
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk) srst = 1'b0;
    repeat (3) @(negedge clk);
    t_reset();
    t_init();
    t_chan();
    t_s2p();
    t_p2s();
    t_partial();
    end_of_test();
  end
  initial begin
    #400000;
    n_fail++;
    end_of_test();
  end
endmodule
